// ==== verilog/imsr_pkg.sv ====
// Constants and types shared by the two-wire bus stop and release logic.
`default_nettype none
package imsr_pkg;
  // Register byte offsets on the bus.
  localparam logic [4:0] OFS_CTRL_TWO   = 5'h00;
  localparam logic [4:0] OFS_CTRL_ONE   = 5'h04;
  localparam logic [4:0] OFS_DATA_BUF   = 5'h08;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] OFS_IRQ_MASK   = 5'h10;
  // Bit positions of control register two and of the status register.
  localparam int BIT_MASTER = 7;
  localparam int BIT_TRX    = 6;
  localparam int BIT_BUSY   = 5;
  localparam int BIT_PIN    = 4;
  localparam int BIT_LRB    = 0;
  // Interrupt status bit positions.
  localparam int IRQ_STOP_DONE = 0;
  localparam int IRQ_RELEASED  = 1;
  localparam int IRQ_START_SEEN = 2;
  localparam int IRQ_WIDTH     = 3;
  // Values after reset.
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_DATA_BUF = 8'h00;
  localparam logic       RST_PIN      = 1'b1;
  localparam logic       RST_LRB      = 1'b1;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;
  // Stop setup and hold time in nanoseconds, clock period in nanoseconds.
  localparam int T_STOP_NS  = 4000;
  localparam int CLK_PER_NS = 50;
  localparam int STOP_CYC   = (T_STOP_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int CNT_W      = 8;
  // Stop and release sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_SDA_LOW  = 3'b001,
    ST_SCL_WAIT = 3'b010,
    ST_SETUP    = 3'b011,
    ST_SDA_REL  = 3'b100,
    ST_REL_WAIT = 3'b101
  } imsr_state_t;
endpackage
`default_nettype wire

// ==== verilog/imsr_sync.sv ====
// Two-stage synchroniser with a third stage kept for edge detection.
`default_nettype none
module imsr_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             nrst,
  // Asynchronous levels in, synchronised and delayed levels out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out,
  output logic      [WIDTH-1:0] prev_out
);
  logic [WIDTH-1:0] meta_reg;

  // Lines idle high, so all stages reset high to avoid a false edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '1;
      sync_out <= '1;
      prev_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
      prev_out <= sync_out;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/imsr_top.sv ====
// Two-wire bus master stop generation, bus release and busy tracking.
`default_nettype none
module imsr_top (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        NRST,
  // Wishbone slave.
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [4:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // Serial data line, open drain.
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE,
  // Serial clock line, open drain.
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE,
  // Interrupt.
  output logic             IRQ
);
  import imsr_pkg::*;

  imsr_state_t      state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic             mst_reg, trx_reg, pin_reg, busy_reg, lrb_reg;
  logic [7:0]       ctrl_one_reg, data_buf_reg;
  logic [IRQ_WIDTH-1:0] irq_st_reg, irq_mask_reg;
  logic             irq_reg;
  logic [1:0]       line_s, line_p;

  // Line samples: bit 1 is the clock line, bit 0 the data line.
  imsr_sync #(.WIDTH(2)) u_sync (
    .clk      (CLK),
    .nrst     (NRST),
    .async_in ({SCL_I, SDA_I}),
    .sync_out (line_s),
    .prev_out (line_p)
  );

  // Bus condition decode on the synchronised lines.
  wire scl_hi    = line_s[1];
  wire sda_hi    = line_s[0];
  wire scl_rise  = line_s[1] & ~line_p[1];
  wire start_det = line_p[0] & ~line_s[0] & line_s[1] & line_p[1];
  wire stop_det  = ~line_p[0] & line_s[0] & line_s[1] & line_p[1];

  // Bus access decode; a request is taken in the cycle before ack.
  wire req     = CYC_I & STB_I & ~ack_reg;
  wire wr      = req & WE_I & SEL_I[0];
  wire hit_c2  = (ADR_I == OFS_CTRL_TWO);
  wire hit_c1  = (ADR_I == OFS_CTRL_ONE);
  wire hit_db  = (ADR_I == OFS_DATA_BUF);
  wire hit_ist = (ADR_I == OFS_IRQ_STATUS);
  wire hit_imk = (ADR_I == OFS_IRQ_MASK);
  wire wr_c2   = wr & hit_c2;
  wire [7:0] wd = DAT_I[7:0];

  // Command patterns on control register two.
  wire stop_req = wr_c2 & busy_reg & (state_reg == ST_IDLE) & wd[BIT_MASTER] & wd[BIT_TRX]
                  & ~wd[BIT_BUSY] & wd[BIT_PIN];
  wire rel_req  = wr_c2 & (state_reg == ST_IDLE) & ~wd[BIT_MASTER] & ~wd[BIT_TRX]
                  & ~wd[BIT_BUSY] & wd[BIT_PIN];
  wire seq_idle = (state_reg == ST_IDLE);
  wire stop_done = (state_reg == ST_SDA_REL) & sda_hi & scl_hi;
  wire rel_done  = (state_reg == ST_REL_WAIT) & scl_hi;

  // Status view returned on a read of control register two.
  wire [7:0] status_v = {mst_reg, trx_reg, busy_reg, pin_reg, 3'h0, lrb_reg};
  wire [31:0] rd_mux =
    hit_c2  ? {24'h0, status_v} :
    hit_c1  ? {24'h0, ctrl_one_reg} :
    hit_db  ? {24'h0, data_buf_reg} :
    hit_ist ? {29'h0, irq_st_reg} :
    hit_imk ? {29'h0, irq_mask_reg} : 32'h0;

  // Sequencer next state; the counter times the data-low hold and stop setup.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = '0;
        if (stop_req) begin
          state_next = ST_SDA_LOW;
        end else if (rel_req) begin
          state_next = ST_REL_WAIT;
        end
      end
      ST_SDA_LOW: begin
        if (cnt_reg == CNT_W'(STOP_CYC - 1)) begin
          state_next = ST_SCL_WAIT;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_SCL_WAIT: begin
        if (scl_hi) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_reg == CNT_W'(STOP_CYC - 1)) begin
          state_next = ST_SDA_REL;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_SDA_REL: begin
        if (stop_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_REL_WAIT: begin
        if (rel_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Open-drain drive: the data line is pulled low until setup has run out,
  // the clock line only while the data line is first pulled down.
  assign SDA_O  = 1'b0;
  assign SCL_O  = 1'b0;
  assign SDA_OE = (state_reg == ST_SDA_LOW) | (state_reg == ST_SCL_WAIT)
                  | (state_reg == ST_SETUP);
  assign SCL_OE = (state_reg == ST_SDA_LOW);

  // Single-cycle answer; unmapped offsets read zero and writes are dropped.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= req;
      dat_reg <= req ? rd_mux : dat_reg;
    end
  end
  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;

  // Mode bits; writes are ignored mid-sequence so a stray write cannot
  // corrupt an ongoing stop. Both mode bits drop once the sequence ends.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mst_reg <= 1'b0;
      trx_reg <= 1'b0;
      pin_reg <= RST_PIN;
    end else if (stop_done | rel_done) begin
      mst_reg <= 1'b0;
      trx_reg <= 1'b0;
    end else if (wr_c2 & seq_idle) begin
      mst_reg <= wd[BIT_MASTER];
      trx_reg <= wd[BIT_TRX];
      pin_reg <= wd[BIT_PIN] | pin_reg;
    end
  end

  // Busy tracking: a start sets it and wins over any clearing event.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det | stop_done | rel_done) begin
      busy_reg <= 1'b0;
    end
  end

  // Last received bit: data level at each clock rise, and the clock level once
  // released, which is always one as the release ends only once the clock line is high.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lrb_reg <= RST_LRB;
    end else if (rel_done) begin
      lrb_reg <= scl_hi;
    end else if (scl_rise) begin
      lrb_reg <= sda_hi;
    end
  end

  // Plain storage for control register one and the data buffer.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_one_reg <= RST_CTRL_ONE;
      data_buf_reg <= RST_DATA_BUF;
    end else begin
      ctrl_one_reg <= (wr & hit_c1) ? wd : ctrl_one_reg;
      data_buf_reg <= (wr & hit_db) ? wd : data_buf_reg;
    end
  end

  // Sticky events; a new event beats a write-one clear in the same cycle.
  wire [IRQ_WIDTH-1:0] irq_ev  = {start_det, rel_done, stop_done};
  wire [IRQ_WIDTH-1:0] irq_clr = (wr & hit_ist) ? wd[IRQ_WIDTH-1:0] : '0;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_st_reg   <= '0;
      irq_mask_reg <= RST_IRQ_MASK;
      irq_reg      <= 1'b0;
    end else begin
      irq_st_reg   <= (irq_st_reg & ~irq_clr) | irq_ev;
      irq_mask_reg <= (wr & hit_imk) ? wd[IRQ_WIDTH-1:0] : irq_mask_reg;
      irq_reg      <= |(((irq_st_reg & ~irq_clr) | irq_ev) & irq_mask_reg);
    end
  end
  assign IRQ = irq_reg;

  // Checks.
  sequence s_clock_freed;
    (state_reg == ST_SCL_WAIT) && scl_hi;
  endsequence
  sequence s_setup_entered;
    ##1 (state_reg == ST_SETUP);
  endsequence

  property p_stop_launch;
    @(posedge CLK) disable iff (!NRST) stop_req |=> (state_reg == ST_SDA_LOW) && SDA_OE;
  endproperty
  a_stop_launch: assert property (p_stop_launch) else $error("Stop not launched.");
  property p_scl_hold;
    @(posedge CLK) disable iff (!NRST)
      ((state_reg == ST_SCL_WAIT) && !scl_hi) |=> (state_reg == ST_SCL_WAIT) && SDA_OE;
  endproperty
  a_scl_hold: assert property (p_scl_hold) else $error("Left wait while clock held.");
  property p_wait_then_setup;
    @(posedge CLK) disable iff (!NRST) s_clock_freed |-> s_setup_entered;
  endproperty
  a_wait_then_setup: assert property (p_wait_then_setup) else $error("No setup.");
  property p_sda_release;
    @(posedge CLK) disable iff (!NRST)
      ((state_reg == ST_SETUP) && (cnt_reg == CNT_W'(STOP_CYC - 1)))
      |=> !SDA_OE && !SCL_OE && (state_reg == ST_SDA_REL);
  endproperty
  a_sda_release: assert property (p_sda_release) else $error("Data not released.");
  property p_setup_bound;
    @(posedge CLK) disable iff (!NRST)
      (state_reg == ST_SETUP) |-> (cnt_reg < CNT_W'(STOP_CYC)) && scl_hi | $past(scl_hi);
  endproperty
  a_setup_bound: assert property (p_setup_bound) else $error("Setup overran.");

  property p_release_lines;
    @(posedge CLK) disable iff (!NRST)
      rel_req |=> !SDA_OE && !SCL_OE && (state_reg == ST_REL_WAIT);
  endproperty
  a_release_lines: assert property (p_release_lines) else $error("Bus not released.");

  property p_busy_clear;
    @(posedge CLK) disable iff (!NRST) (stop_det && !start_det) |=> !busy_reg;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("Busy not cleared.");

  property p_irq_level;
    @(posedge CLK) disable iff (!NRST)
      ##1 (IRQ == |($past(irq_st_reg & ~irq_clr | irq_ev) & $past(irq_mask_reg)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong.");
endmodule
`default_nettype wire

// ==== tb/imsr_bus_model.sv ====
// Behavioural model of the other parties on the two open-drain bus lines.
`default_nettype none
module imsr_bus_model (
  // Device pull-down enables.
  input  wire logic sda_oe,
  input  wire logic scl_oe,
  // Resolved line levels.
  output wire logic sda,
  output wire logic scl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hold_sda = 1'b0;
  logic hold_scl = 1'b0;
  // Pull-ups win unless some party pulls a line low, so a released line reads high.
  assign sda = !(sda_oe || hold_sda);
  assign scl = !(scl_oe || hold_scl);
  // Start, eight bits at a 400 ns clock, then the clock is stretched low.
  task automatic frame(input logic [7:0] bits);
    hold_sda = 1'b1;
    #200;
    for (int i = 7; i >= 0; i--) begin
      hold_scl = 1'b1;
      #100 hold_sda = !bits[i];
      #100 hold_scl = 1'b0;
      #200;
    end
    hold_scl = 1'b1;
    // The data line is left high, so the sender has finished before any restart.
    #100 hold_sda = 1'b0;
  endtask
  // Ends the clock stretch.
  task automatic unstretch();
    hold_scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/imsr_top_tb.sv ====
// Self-checking bench for the stop, release and busy logic.
`default_nettype none
module imsr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import imsr_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        sda_oe;
  logic        scl_oe;
  logic        sda_o;
  logic        scl_o;
  logic        irq;
  wire logic   sda;
  wire logic   scl;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc_cnt = 0;
  int          n;
  logic [31:0] rd;
  logic [7:0]  pat;
  // Restart setup wait of 4.7 us at 50 ns per cycle.
  localparam int RESTART_WAIT = 94;
  // Clock at 50 ns period.
  always #25 clk = ~clk;
  imsr_top u_dut (.CLK(clk), .NRST(nrst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe), .IRQ(irq));
  imsr_bus_model u_bus (.sda_oe(sda_oe), .scl_oe(scl_oe), .sda(sda), .scl(scl));
  // Expected status byte from the busy flag and last received bit.
  function automatic logic [7:0] stat(input logic busy, input logic lrb);
    stat = 8'h00;
    stat[BIT_PIN] = RST_PIN;
    stat[BIT_BUSY] = busy;
    stat[BIT_LRB] = lrb;
  endfunction
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    check_reg({31'h0, got}, {31'h0, exp}, what);
  endtask
  // One classic cycle; ack is sampled at the rising edge, then the request is dropped.
  task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    t = 0;
    // Waits without a limit of its own; the bench watchdog ends a hang.
    // The answer follows the take edge by one cycle, so it is seen at the second edge.
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1);
    check_reg(t, 32'd2, "bus answer latency");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, 4'hf, {24'h0, d}, q);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e, input string what);
    logic [31:0] q;
    wb(1'b0, a, 4'hf, 32'h0, q);
    check_reg(q, {24'h0, e}, what);
  endtask
  // The interrupt is registered, so it is looked at half a cycle on.
  task automatic irq_is(input logic e);
    @(negedge clk);
    check_bit(irq, e, "irq");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Main sequence.
  initial begin
    n = $urandom(32'h3714);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rchk(OFS_CTRL_TWO, stat(1'b0, RST_LRB), "reset status");
    rchk(OFS_CTRL_ONE, RST_CTRL_ONE, "reset ctrl one");
    rchk(OFS_IRQ_MASK, {5'h0, RST_IRQ_MASK}, "reset mask");
    rchk(5'h14, 8'h00, "unmapped");
    // Storage readback; a write with lane zero off must be dropped.
    pat = 8'($urandom);
    wr(OFS_DATA_BUF, pat);
    wb(1'b1, OFS_DATA_BUF, 4'he, {24'h0, ~pat}, rd);
    rchk(OFS_DATA_BUF, pat, "data buffer");
    pat = 8'($urandom);
    wr(OFS_CTRL_ONE, pat);
    rchk(OFS_CTRL_ONE, pat, "ctrl one");
    // Another party starts a frame and stretches the clock.
    pat = 8'($urandom);
    u_bus.frame(pat);
    rchk(OFS_CTRL_TWO, stat(1'b1, pat[0]), "busy after start");
    rchk(OFS_IRQ_STATUS, 8'h04, "start event");
    wr(OFS_IRQ_MASK, 8'h07);
    irq_is(1'b1);
    wr(OFS_IRQ_STATUS, 8'h04);
    irq_is(1'b0);
    // Stop request: data low, clock low for the hold, then waits on the stretch.
    wr(OFS_CTRL_TWO, 8'hd8);
    @(negedge clk);
    check_bit(sda_oe, 1'b1, "stop data low");
    check_bit(sda_o | scl_o, 1'b0, "open drain drives low");
    // The cycle after the take edge passed inside the write, so it is counted here.
    n = 1;
    while (scl_oe === 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
    check_reg(n, STOP_CYC, "clock low count");
    // The data line stays pulled low while the clock is stretched.
    repeat (200) @(negedge clk);
    check_bit(sda_oe, 1'b1, "stop held while stretched");
    u_bus.unstretch();
    n = 0;
    while (sda_oe === 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
    check_bit(n > STOP_CYC && n <= STOP_CYC + 5, 1'b1, "setup before data release");
    check_bit(scl, 1'b1, "clock high at stop");
    repeat (4) @(negedge clk);
    rchk(OFS_CTRL_TWO, stat(1'b0, 1'b0), "idle after stop");
    rchk(OFS_IRQ_STATUS, 8'h01, "stop event");
    irq_is(1'b1);
    wr(OFS_IRQ_MASK, 8'h00);
    irq_is(1'b0);
    wr(OFS_IRQ_STATUS, 8'h07);
    // Release without a stop: both lines let go, bus still busy until the stretch ends.
    pat = 8'($urandom);
    u_bus.frame(pat);
    // Master select is set first, so the release never writes zero over zero.
    wr(OFS_CTRL_TWO, 8'hc8);
    wr(OFS_CTRL_TWO, 8'h18);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (sda_oe !== 1'b0 || scl_oe !== 1'b0) n++;
    end
    check_reg(n, 0, "lines released");
    rchk(OFS_CTRL_TWO, stat(1'b1, pat[0]), "still busy");
    u_bus.unstretch();
    n = 0;
    do begin
      wb(1'b0, OFS_CTRL_TWO, 4'hf, 32'h0, rd);
      n++;
    end while (rd[BIT_BUSY] !== 1'b0 && n < 20);
    check_reg(rd, {24'h0, stat(1'b0, 1'b1)}, "free after release");
    check_bit(sda_oe, 1'b0, "no stop on release");
    rchk(OFS_IRQ_STATUS, 8'h06, "release event");
    // Restart preparation once the bus is judged free; start itself is not built here.
    check_bit(rd[BIT_LRB], 1'b1, "clock free after release");
    check_bit(scl, 1'b1, "clock pin high before restart");
    repeat (RESTART_WAIT) @(posedge clk);
    pat = (8'($urandom) | 8'h10) & 8'hf7;
    wr(OFS_CTRL_ONE, pat);
    rchk(OFS_CTRL_ONE, pat, "acknowledge mode");
    wr(OFS_DATA_BUF, 8'($urandom));
    wr(OFS_CTRL_TWO, 8'hf8);
    rchk(OFS_CTRL_TWO, stat(1'b0, 1'b1) | 8'hc0, "restart mode bits");
    // A stop request with the bus idle is not launched.
    wr(OFS_CTRL_TWO, 8'hd8);
    repeat (3) @(negedge clk);
    check_bit(sda_oe, 1'b0, "no stop when idle");
    // Lockup: another party keeps the clock low and no interrupt comes within the limit,
    // so the interface is reset and the data is sent again at a shifted moment.
    wr(OFS_IRQ_STATUS, 8'h07);
    wr(OFS_IRQ_MASK, 8'h03);
    pat = 8'($urandom);
    u_bus.frame(pat);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      n++;
      @(negedge clk);
    end
    check_reg(n, 200, "no interrupt while locked");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk(OFS_CTRL_TWO, stat(1'b0, RST_LRB), "status after reset");
    rchk(OFS_IRQ_MASK, {5'h0, RST_IRQ_MASK}, "mask after reset");
    u_bus.unstretch();
    repeat (1 + $urandom % 8) @(posedge clk);
    wr(OFS_DATA_BUF, pat);
    rchk(OFS_DATA_BUF, pat, "data resent");
    complete_run();
  end
endmodule
`default_nettype wire
